//--- bench/dac_serial_input_interface_tb.sv
`timescale 1ns/1ps
module dac_serial_input_interface_tb;
  import dsi_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic force_fl = 1'b0;
  logic word_ready = 1'b0;
  logic sclk, sin, strobe, serial_out, async_mode, floor_active, in_ready, word_valid;
  logic [WORD_W-1:0] word;
  logic so_q = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int pulse_cnt = 0;
  always #20 mclk = ~mclk;
  dsi_host_model u_host (.i_mclk(mclk), .o_serial_clk(sclk), .o_serial_in(sin),
    .o_update_strobe(strobe));
  dsi_serial_in u_dut (.i_mclk(mclk), .i_resetn(resetn), .i_serial_clk(sclk),
    .i_serial_in(sin), .i_update_strobe(strobe), .i_floor_force(force_fl),
    .o_serial_out(serial_out), .o_async_mode(async_mode), .o_floor_active(floor_active),
    .o_in_ready(in_ready), .o_word_valid(word_valid), .i_word_ready(word_ready),
    .o_word(word));
  // Count error pulses seen in async mode
  always @(posedge mclk) begin
    so_q <= serial_out;
    if (async_mode === 1'b1 && serial_out === 1'b1 && so_q !== 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end
  // ==========================================================
  // Helpers
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pop();
    @(negedge mclk);
    word_ready = 1'b1;
    @(negedge mclk);
    word_ready = 1'b0;
    idle(2);
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d errors", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
  // ==========================================================
  // Tests
  initial begin
    idle(6);
    resetn = 1'b1;
    idle(6);
    u_host.shift_word(16'hA5C3);
    idle(6);
    check(16'(serial_out), 16'h0001);
    u_host.latch();
    u_host.shift_word(16'h3C96);
    idle(6);
    check(16'(serial_out), 16'h0000);
    u_host.latch();
    check(16'(in_ready), 16'h0000);
    check(16'(word_valid), 16'h0001);
    check(word, 16'hA5C3);
    pop();
    check(word, 16'h3C96);
    pop();
    check(16'(word_valid), 16'h0000);
    $display("test three_wire done");
    force_fl = 1'b1;
    idle(8);
    check(16'(floor_active), 16'h0001);
    force_fl = 1'b0;
    idle(8);
    check(16'(floor_active), 16'h0001);
    // Mode entry latches the shift register once more
    u_host.enter_async();
    check(16'(async_mode), 16'h0001);
    check(word, 16'h3C96);
    pop();
    check(16'(floor_active), 16'h0000);
    $display("test floor done");
    u_host.send_frame(16'hB4E1, STOP_LVL);
    check(16'(word_valid), 16'h0001);
    check(word, 16'hB4E1);
    check(16'(pulse_cnt), 16'h0000);
    pop();
    u_host.glitch();
    check(16'(word_valid), 16'h0000);
    u_host.send_frame(16'h8001, STOP_LVL);
    u_host.send_frame(16'h7FFE, STOP_LVL);
    check(16'(in_ready), 16'h0000);
    check(word, 16'h8001);
    pop();
    check(word, 16'h7FFE);
    pop();
    $display("test async_good done");
    u_host.send_frame(16'h1234, START_LVL);
    check(16'(pulse_cnt), 16'h0001);
    check(16'(word_valid), 16'h0000);
    $display("test async_error done");
    report_and_stop();
  end
endmodule // dac_serial_input_interface_tb

//--- bench/dsi_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: drives clock, data and strobe pins
module dsi_host_model
  import dsi_pkg::*;
(
  input wire logic i_mclk,
  output logic o_serial_clk,
  output logic o_serial_in,
  output logic o_update_strobe
);
  initial begin
    o_serial_clk = 1'b0;
    o_serial_in = IDLE_LVL;
    o_update_strobe = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Six mclk per phase so each edge survives the pin sync
  task automatic pulse_clk(input int n);
    repeat (n) begin
      wait_n(6);
      o_serial_clk = 1'b1;
      wait_n(6);
      o_serial_clk = 1'b0;
    end
  endtask
  task automatic shift_word(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      o_serial_in = w[i];
      pulse_clk(1);
    end
    // Line no longer held: show the inverse
    o_serial_in = ~w[0];
  endtask
  task automatic latch();
    wait_n(6);
    o_update_strobe = 1'b1;
    wait_n(8);
    o_update_strobe = 1'b0;
    wait_n(6);
  endtask
  task automatic enter_async();
    o_serial_in = IDLE_LVL;
    wait_n(6);
    o_update_strobe = 1'b1;
    pulse_clk(17);
    wait_n(12);
  endtask
  task automatic send_frame(input logic [WORD_W-1:0] w, input logic stop_bit);
    o_serial_in = START_LVL;
    pulse_clk(16);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      o_serial_in = w[i];
      pulse_clk(16);
    end
    o_serial_in = stop_bit;
    pulse_clk(16);
    o_serial_in = IDLE_LVL;
    wait_n(12);
  endtask
  // Short low glitch that is high again by the start centre
  task automatic glitch();
    o_serial_in = START_LVL;
    pulse_clk(3);
    o_serial_in = IDLE_LVL;
    pulse_clk(20);
  endtask
endmodule // dsi_host_model

//--- verilog/dsi_fifo2.sv
`timescale 1ns/1ps
module dsi_fifo2 #(
  parameter int unsigned W = 16
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  // ==========================================================
  // Two-entry store
  logic [W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_r != 2'h2);
  assign o_out_valid = (cnt_r != 2'h0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_r[rp_r];

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      if (push && !pop) cnt_r <= cnt_r + 2'h1;
      else if (pop && !push) cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule // dsi_fifo2

//--- verilog/dsi_pkg.sv
package dsi_pkg;
  // ==========================================================
  // Word and cell geometry
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CELL_CLKS = 16;
  localparam int unsigned HALF_CELL = CELL_CLKS / 2;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned BIT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(HALF_CELL);
  localparam logic [CNT_W-1:0] CNT_CELL = CNT_W'(CELL_CLKS);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_W - 1);
  localparam logic [BIT_W-1:0] BIT_ZERO = 4'h0;
  // ==========================================================
  // Frame levels
  localparam logic START_LVL = 1'b0;
  localparam logic STOP_LVL = 1'b1;
  localparam logic IDLE_LVL = 1'b1;
  // ==========================================================
  // Mode detect: strobe high across this many serial clocks
  localparam int unsigned HOLD_W = 5;
  localparam logic [HOLD_W-1:0] ASYNC_HOLD = 5'h10;
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 5'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam int unsigned SYNC_N = 4;
  // ==========================================================
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } dsi_rx_e;
endpackage

//--- verilog/dsi_serial_in.sv
`timescale 1ns/1ps
// How it works
// - Async words are framed by a 0 start bit and a 1 stop bit.
// - Async bits are sampled on the serial clock edge at the cell centre.
// - Each async bit cell lasts sixteen serial clocks.
// - Cell counting starts at the first serial clock after the falling start edge.
// - Top data bit sampled at clock 24, each next bit 16 clocks later.
// - A good stop bit hands the received word to the converter.
// - A low stop bit gives a one-clock high pulse on the serial output.
// - On a framing error the word is dropped, converter value kept.
// - Three-wire: strobe rising edge loads the whole shift register to the converter.
// - Strobe held permanently high selects async mode, else three-wire.
// - Three-wire: shift on each serial clock rise, shifted-out bit drives serial output.
// - Floor force drives output to bottom and holds it; input data kept.
module dsi_serial_in
  import dsi_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_serial_clk,
  input wire logic i_serial_in,
  input wire logic i_update_strobe,
  input wire logic i_floor_force,
  output logic o_serial_out,
  output logic o_async_mode,
  output logic o_floor_active,
  output logic o_in_ready,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [WORD_W-1:0] o_word
);
  // ==========================================================
  // Pin synchronisers: a level moves once stages 2 and 3 agree
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] s1_r;
  logic [SYNC_N-1:0] s2_r;
  logic [SYNC_N-1:0] s3_r;
  logic [SYNC_N-1:0] lvl_r;
  logic [SYNC_N-1:0] lvl_d_r;

  assign pin_raw = {i_floor_force, i_update_strobe, i_serial_in, i_serial_clk};

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      lvl_d_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < SYNC_N; i++) begin
        if (s2_r[i] == s3_r[i]) lvl_r[i] <= s3_r[i];
      end
      lvl_d_r <= lvl_r;
    end
  end

  logic sc_en;
  logic din;
  logic strobe_lvl;
  logic strobe_rise;
  logic floor_lvl;
  logic din_fall;

  assign sc_en = lvl_r[0] && !lvl_d_r[0];
  assign din = lvl_r[1];
  assign din_fall = !lvl_r[1] && lvl_d_r[1];
  assign strobe_lvl = lvl_r[2];
  assign strobe_rise = lvl_r[2] && !lvl_d_r[2];
  assign floor_lvl = lvl_r[3];

  // ==========================================================
  // Mode select
  // A strobe pulse in three-wire mode sees no clock edges, so only a
  // strobe tied high accumulates serial clocks and enters async mode.
  logic [HOLD_W-1:0] hold_r;
  logic async_r;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_r <= HOLD_ZERO;
      async_r <= 1'b0;
    end else if (!strobe_lvl) begin
      hold_r <= HOLD_ZERO;
      async_r <= 1'b0;
    end else if (sc_en && !async_r) begin
      if (hold_r == ASYNC_HOLD - 5'h01) async_r <= 1'b1;
      hold_r <= hold_r + 5'h01;
    end
  end

  // ==========================================================
  // Three-wire shift register
  logic [WORD_W-1:0] shift_r;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_r <= WORD_ZERO;
    end else if (!async_r && sc_en) begin
      shift_r <= {shift_r[WORD_W-2:0], din};
    end
  end

  // ==========================================================
  // Async receiver, counting in serial clock edges
  dsi_rx_e st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [BIT_W-1:0] bit_r;
  logic [WORD_W-1:0] rxsh_r;
  logic ferr_r;
  logic smp_half;
  logic smp_cell;
  logic stop_good;
  logic stop_bad;

  assign cnt_nxt = cnt_r + 5'h01;
  assign smp_half = sc_en && (cnt_nxt == CNT_HALF);
  assign smp_cell = sc_en && (cnt_nxt == CNT_CELL);
  assign stop_good = (st_r == RX_STOP) && smp_cell && (din == STOP_LVL);
  assign stop_bad = (st_r == RX_STOP) && smp_cell && (din != STOP_LVL);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= RX_IDLE;
      cnt_r <= CNT_ZERO;
      bit_r <= BIT_ZERO;
    end else if (!async_r) begin
      st_r <= RX_IDLE;
      cnt_r <= CNT_ZERO;
    end else begin
      case (st_r)
        RX_IDLE: begin
          if (din_fall) begin
            st_r <= RX_START;
            cnt_r <= CNT_ZERO;
          end
        end
        RX_START: begin
          if (smp_half) begin
            cnt_r <= CNT_ZERO;
            bit_r <= BIT_ZERO;
            if (din == START_LVL) st_r <= RX_DATA;
            else st_r <= RX_IDLE;
          end else if (sc_en) begin
            cnt_r <= cnt_nxt;
          end
        end
        RX_DATA: begin
          if (smp_cell) begin
            cnt_r <= CNT_ZERO;
            bit_r <= bit_r + 4'h1;
            if (bit_r == BIT_LAST) st_r <= RX_STOP;
          end else if (sc_en) begin
            cnt_r <= cnt_nxt;
          end
        end
        RX_STOP: begin
          if (smp_cell) begin
            cnt_r <= CNT_ZERO;
            st_r <= RX_IDLE;
          end else if (sc_en) begin
            cnt_r <= cnt_nxt;
          end
        end
        default: st_r <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxsh_r <= WORD_ZERO;
    end else if (st_r == RX_DATA && smp_cell) begin
      rxsh_r <= {rxsh_r[WORD_W-2:0], din};
    end
  end

  // Pulse spans the serial clock period after the stop sample
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ferr_r <= 1'b0;
    end else if (stop_bad && async_r) begin
      ferr_r <= 1'b1;
    end else if (sc_en || !async_r) begin
      ferr_r <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_serial_out <= 1'b0;
    end else begin
      o_serial_out <= async_r ? ferr_r : shift_r[WORD_W-1];
    end
  end

  // ==========================================================
  // Word hand-over into the two-entry buffer
  // A word that arrives while one is still pending replaces it; the
  // host sees o_in_ready low while the buffer is full.
  logic word_take;
  logic [WORD_W-1:0] take_word;
  logic pend_r;
  logic [WORD_W-1:0] pend_word_r;
  logic fifo_in_ready;

  assign word_take = (async_r && stop_good) || (!async_r && strobe_rise);
  assign take_word = async_r ? rxsh_r : shift_r;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_r <= 1'b0;
      pend_word_r <= WORD_ZERO;
    end else if (word_take) begin
      pend_r <= 1'b1;
      pend_word_r <= take_word;
    end else if (fifo_in_ready) begin
      pend_r <= 1'b0;
    end
  end

  dsi_fifo2 #(.W(WORD_W)) u_buf (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_in_valid(pend_r),
    .o_in_ready(fifo_in_ready),
    .i_in_data(pend_word_r),
    .o_out_valid(o_word_valid),
    .i_out_ready(i_word_ready),
    .o_out_data(o_word)
  );

  // ==========================================================
  // Floor force: sticky until the next word reaches the converter
  logic floor_r;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      floor_r <= 1'b0;
    end else if (floor_lvl) begin
      floor_r <= 1'b1;
    end else if (o_word_valid && i_word_ready) begin
      floor_r <= 1'b0;
    end
  end

  assign o_floor_active = floor_r;
  assign o_async_mode = async_r;
  assign o_in_ready = fifo_in_ready;

  // ==========================================================
  // Checks
  a_mode_strobe: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    async_r |-> strobe_lvl)
    else $error("async mode without strobe held high");
  a_start_count: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (async_r && st_r == RX_IDLE && din_fall) |=> (st_r == RX_START && cnt_r == CNT_ZERO))
    else $error("start edge did not begin the cell count");
  a_start_noise: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (async_r && st_r == RX_START && smp_half && din) |=> st_r == RX_IDLE)
    else $error("high start centre not treated as noise");
  a_data_sample: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (st_r == RX_DATA && sc_en && cnt_r == CNT_CELL - 5'h01)
      |=> rxsh_r[0] == $past(din))
    else $error("data bit not taken at cell centre");
  a_stop_push: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (async_r && stop_good) |=> (pend_r && pend_word_r == $past(rxsh_r)))
    else $error("good frame not handed over");
  a_ferr_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (async_r && stop_bad) |=> ferr_r ##1 o_serial_out)
    else $error("framing error pulse missing");
  a_ferr_width: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (ferr_r && sc_en) |=> !ferr_r)
    else $error("framing error pulse longer than one clock");
  a_err_no_take: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (async_r && stop_bad) |-> !word_take)
    else $error("bad frame updated the converter");
  a_stop_idle: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (st_r == RX_STOP && smp_cell && async_r) |=> st_r == RX_IDLE)
    else $error("receiver not idle after stop sample");
  a_tw_shift: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (!async_r && sc_en) |=> shift_r == {$past(shift_r[WORD_W-2:0]), $past(din)})
    else $error("three-wire shift wrong");
  a_tw_latch: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (!async_r && strobe_rise) |=> (pend_r && pend_word_r == $past(shift_r)))
    else $error("strobe edge did not load shift register");
  a_floor_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    floor_lvl |=> o_floor_active)
    else $error("floor force not applied");

  c_good_frame: cover property (@(posedge i_mclk) disable iff (!i_resetn) async_r && stop_good);
  c_bad_frame: cover property (@(posedge i_mclk) disable iff (!i_resetn) async_r && stop_bad);
  c_tw_latch: cover property (@(posedge i_mclk) disable iff (!i_resetn) !async_r && strobe_rise);
  c_buf_full: cover property (@(posedge i_mclk) disable iff (!i_resetn) !fifo_in_ready);
endmodule // dsi_serial_in
